// file: verilog/sensor_ctl_defines.svh
// constants for the measurement control register block
`ifndef SENSOR_CTL_DEFINES_SVH
`define SENSOR_CTL_DEFINES_SVH
`define CTL_ADDR        8'h26
`define CTL_RESET       8'h00
`define BIT_HEIGHT      7
`define BIT_RSVD        6
`define OS_HI           5
`define OS_LO           3
`define BIT_REBOOT      2
`define BIT_ONE_SHOT    1
`define BIT_RUN         0
`define CLK_PERIOD_NS   8
`define NS_PER_MS       1000000
`define MS_PER_SEC      1000
`define SPACING_MS_0    6
`define SPACING_MS_1    10
`define SPACING_MS_2    18
`define SPACING_MS_3    34
`define SPACING_MS_4    66
`define SPACING_MS_5    130
`define SPACING_MS_6    258
`define SPACING_MS_7    512
`define BOOT_CYCLES     16
`define BYTE_LAST_BIT   4'h7
`define ACK_SLOT        4'h8
`endif

// file: verilog/sensor_ctl_pkg.sv
// types for the measurement control register block
`default_nettype none
package sensor_ctl_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_ACTIVE  = 2'b01,
    ST_CONVERT = 2'b10,
    ST_BOOT    = 2'b11
  } run_state_t;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_ADDR = 3'b001,
    SER_PTR  = 3'b010,
    SER_WR   = 3'b011,
    SER_RD   = 3'b100
  } ser_state_t;
endpackage
`default_nettype wire

// file: verilog/measurement_control.sv
// measurement control register with serial bus slave, measurement sequencer and reboot
`include "sensor_ctl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module measurement_control #(
  parameter logic [6:0] DEV_ADDR  = 7'h2a,   // arbitrary bus address
  parameter int         MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
) (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic [3:0] interval_exp_in,
  output logic            height_mode_out,
  output logic [2:0]      oversample_code_out,
  output logic            run_active_out,
  output logic            converting_out,
  output logic            convert_start_out,
  output logic            sample_ready_out,
  output logic            block_reset_out
);
  generate
    if (MS_CYCLES < 1) begin : g_bad_ms
      $error("MS_CYCLES must be at least one");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SPC_MS [8] = '{`SPACING_MS_0, `SPACING_MS_1, `SPACING_MS_2, `SPACING_MS_3,
                                `SPACING_MS_4, `SPACING_MS_5, `SPACING_MS_6, `SPACING_MS_7};
  localparam logic [47:0] SEC_CYC = 48'(`MS_PER_SEC) * 48'(MS_CYCLES);
  localparam logic [4:0]  BOOT_LAST = 5'(`BOOT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  sensor_ctl_pkg::run_state_t st_r;
  sensor_ctl_pkg::ser_state_t ser_r;
  logic        height_r, ost_r, run_r, boot_pend_r, ost_pend_r, one_shot_r;
  logic [2:0]  os_r;
  logic [31:0] conv_cnt_r;
  logic [47:0] per_cnt_r;
  logic [4:0]  boot_cnt_r;
  logic        start_r, ready_r;
  logic [2:0]  scl_s_r, sda_s_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r, ptr_r, tx_r;
  logic        ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial bus decode; link pins pass two flops before use
  wire scl_rise  = scl_s_r[1] & ~scl_s_r[2];
  wire scl_fall  = ~scl_s_r[1] & scl_s_r[2];
  wire bus_start = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
  wire bus_stop  = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
  wire byte_done = scl_fall & (bit_r == `BYTE_LAST_BIT);
  wire addr_hit  = (sh_r[7:1] == DEV_ADDR);
  wire ptr_ctl   = (ptr_r == `CTL_ADDR);
  wire wr_ctl    = byte_done & (ser_r == sensor_ctl_pkg::SER_WR) & ptr_ctl;
  wire boot_go   = wr_ctl & sh_r[`BIT_REBOOT];
  wire ost_set   = wr_ctl & sh_r[`BIT_ONE_SHOT] & ~ost_r;
  // reboot bit and reserved bit always read zero
  wire [7:0] ctl_rd  = {height_r, 1'b0, os_r, 1'b0, ost_r, run_r};
  wire [7:0] rd_data = ptr_ctl ? ctl_rd : 8'h00;
  wire       drv_low = ack_r | ((ser_r == sensor_ctl_pkg::SER_RD) & ~bit_r[3] & ~tx_r[7]);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer decode
  wire in_boot   = (st_r == sensor_ctl_pkg::ST_BOOT);
  wire in_conv   = (st_r == sensor_ctl_pkg::ST_CONVERT);
  wire [31:0] conv_len = 32'(SPC_MS[os_r]) * 32'(MS_CYCLES);
  wire conv_done = in_conv & (conv_cnt_r >= conv_len - 32'h1);
  wire [47:0] per_len = SEC_CYC << interval_exp_in;
  wire per_hit   = (per_cnt_r >= per_len - 48'h1);
  wire trig      = ost_pend_r | ost_set;

  sensor_ctl_pkg::run_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sensor_ctl_pkg::ST_STANDBY: begin
        if (boot_pend_r) begin
          st_nxt = sensor_ctl_pkg::ST_BOOT;
        end else if (run_r) begin
          st_nxt = sensor_ctl_pkg::ST_ACTIVE;
        end else if (trig) begin
          st_nxt = sensor_ctl_pkg::ST_CONVERT;
        end
      end
      sensor_ctl_pkg::ST_ACTIVE: begin
        if (boot_pend_r | ~run_r) begin
          st_nxt = sensor_ctl_pkg::ST_STANDBY;
        end else if (trig | per_hit) begin
          st_nxt = sensor_ctl_pkg::ST_CONVERT;
        end
      end
      sensor_ctl_pkg::ST_CONVERT: begin
        if (boot_pend_r | (~run_r & ~one_shot_r)) begin
          st_nxt = sensor_ctl_pkg::ST_STANDBY;
        end else if (conv_done) begin
          st_nxt = one_shot_r ? sensor_ctl_pkg::ST_STANDBY : sensor_ctl_pkg::ST_ACTIVE;
        end
      end
      sensor_ctl_pkg::ST_BOOT: begin
        if (boot_cnt_r == BOOT_LAST) begin
          st_nxt = sensor_ctl_pkg::ST_STANDBY;
        end
      end
      default: st_nxt = sensor_ctl_pkg::ST_STANDBY;
    endcase
  end
  wire conv_enter = (st_nxt == sensor_ctl_pkg::ST_CONVERT) & ~in_conv;

  ////////////////////////////////////////////////////////////////////////////
  // link pin synchronisers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else if (ce_in) begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial slave, held idle while rebooting
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in | (ce_in & in_boot)) begin
      ser_r <= sensor_ctl_pkg::SER_IDLE;
      bit_r <= 4'h0;
      sh_r  <= 8'h00;
      ptr_r <= 8'h00;
      tx_r  <= 8'hff;
      ack_r <= 1'b0;
    end else if (ce_in) begin
      if (bus_start) begin
        ser_r <= sensor_ctl_pkg::SER_ADDR;
        bit_r <= 4'hf;   // the clock fall that ends a start is not a data bit
        ack_r <= 1'b0;
      end else if (bus_stop) begin
        ser_r <= sensor_ctl_pkg::SER_IDLE;
        ack_r <= 1'b0;
      end else if (scl_rise & ~bit_r[3]) begin
        sh_r <= {sh_r[6:0], sda_s_r[1]};
      end else if (scl_rise & (ser_r == sensor_ctl_pkg::SER_RD) & sda_s_r[1]) begin
        ser_r <= sensor_ctl_pkg::SER_IDLE;   // master nack ends the read
      end else if (byte_done) begin
        bit_r <= `ACK_SLOT;
        case (ser_r)
          sensor_ctl_pkg::SER_ADDR: begin
            ack_r <= addr_hit;
            ser_r <= ~addr_hit ? sensor_ctl_pkg::SER_IDLE :
                     sh_r[0] ? sensor_ctl_pkg::SER_RD : sensor_ctl_pkg::SER_PTR;
          end
          sensor_ctl_pkg::SER_PTR: begin
            ack_r <= 1'b1;
            ptr_r <= sh_r;
            ser_r <= sensor_ctl_pkg::SER_WR;
          end
          sensor_ctl_pkg::SER_WR: begin
            ack_r <= 1'b1;
            ptr_r <= ptr_r + 8'h01;
          end
          default: ack_r <= 1'b0;
        endcase
      end else if (scl_fall & bit_r[3]) begin
        bit_r <= 4'h0;
        ack_r <= 1'b0;
        if (ser_r == sensor_ctl_pkg::SER_RD) begin
          tx_r  <= rd_data;
          ptr_r <= ptr_r + 8'h01;
        end
      end else if (scl_fall) begin
        bit_r <= bit_r + 4'h1;
        if (ser_r == sensor_ctl_pkg::SER_RD) begin
          tx_r <= {tx_r[6:0], 1'b1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; boot reloads defaults
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in | (ce_in & in_boot)) begin
      {height_r, os_r, ost_r, run_r} <= 6'h00;
      boot_pend_r <= 1'b0;
      ost_pend_r  <= 1'b0;
    end else if (ce_in) begin
      if (wr_ctl) begin
        height_r <= sh_r[`BIT_HEIGHT];
        os_r     <= sh_r[`OS_HI:`OS_LO];
        run_r    <= sh_r[`BIT_RUN] & ~boot_go;
        ost_r    <= sh_r[`BIT_ONE_SHOT];
      end else if (boot_pend_r) begin
        run_r    <= 1'b0;
      end else if (conv_done & one_shot_r) begin
        ost_r    <= 1'b0;   // a host write in the same cycle wins
      end
      if (boot_go) begin
        boot_pend_r <= 1'b1;
      end
      // a conversion entered now serves a one-shot raised now; pending it too would rerun it
      if (conv_enter) begin
        ost_pend_r <= 1'b0;
      end else if (ost_set) begin
        ost_pend_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_r       <= sensor_ctl_pkg::ST_STANDBY;
      one_shot_r <= 1'b0;
      conv_cnt_r <= 32'h0;
      per_cnt_r  <= 48'h0;
      boot_cnt_r <= 5'h0;
      start_r    <= 1'b0;
      ready_r    <= 1'b0;
    end else if (ce_in) begin
      st_r       <= st_nxt;
      start_r    <= conv_enter;
      ready_r    <= conv_done & ~boot_pend_r;
      boot_cnt_r <= in_boot ? boot_cnt_r + 5'h1 : 5'h0;
      conv_cnt_r <= in_conv ? conv_cnt_r + 32'h1 : 32'h0;
      if (conv_enter) begin
        one_shot_r <= ~run_r;
      end
      // step period counts from each conversion start
      if (conv_enter | ~run_r) begin
        per_cnt_r <= 48'h0;
      end else if (~per_hit) begin
        per_cnt_r <= per_cnt_r + 48'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_out             = 1'b0;
  assign sda_oe_n_out        = ~drv_low;
  assign height_mode_out     = height_r;
  assign oversample_code_out = os_r;
  assign run_active_out      = (st_r == sensor_ctl_pkg::ST_ACTIVE) | (in_conv & ~one_shot_r);
  assign converting_out      = in_conv;
  assign convert_start_out   = start_r;
  assign sample_ready_out    = ready_r;
  assign block_reset_out     = in_boot;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // boot length is tracked by boot_cnt_r, so the check keys on its last count
  sequence boot_last;
    in_boot && ce_in && (boot_cnt_r == BOOT_LAST);
  endsequence
  sequence boot_exit;
    (st_r == sensor_ctl_pkg::ST_STANDBY) && (ctl_rd == `CTL_RESET);
  endsequence

  a_boot_reload: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    boot_last |=> boot_exit)
    else $error("boot did not reload defaults");
  a_boot_standby: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(in_boot) |-> $past(st_r) == sensor_ctl_pkg::ST_STANDBY && !run_r)
    else $error("boot entered from non-standby");
  a_reboot_taken: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    boot_go && ce_in ##1 ce_in [*3] |-> ##[1:3] in_boot)
    else $error("reboot request lost");
  a_serial_reset: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    in_boot && ce_in |=> ser_r == sensor_ctl_pkg::SER_IDLE && sda_oe_n_out)
    else $error("serial slave active during boot");
  a_rd_zero_bits: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ser_r == sensor_ctl_pkg::SER_RD && scl_fall && bit_r[3] && ptr_ctl && ce_in |=> !tx_r[2] && !tx_r[6])
    else $error("reboot or reserved bit read as one");
  a_oneshot_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    conv_done && one_shot_r && !wr_ctl && !boot_pend_r && ce_in |=> !ost_r && st_r == sensor_ctl_pkg::ST_STANDBY)
    else $error("one-shot did not finish");
  a_active_ost_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    conv_done && !one_shot_r && ost_r && !wr_ctl && ce_in |=> ost_r)
    else $error("one-shot cleared while active");
  a_conv_length: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    conv_done && ce_in |-> conv_cnt_r == conv_len - 32'h1)
    else $error("conversion length wrong");
  a_ost_starts: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ost_set && st_r == sensor_ctl_pkg::ST_ACTIVE && run_r && !boot_pend_r && ce_in |=> in_conv && convert_start_out)
    else $error("one-shot did not start measurement");
  a_mode_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_ctl && !in_boot && ce_in |=> height_mode_out == $past(sh_r[`BIT_HEIGHT]) && oversample_code_out == $past(sh_r[`OS_HI:`OS_LO]))
    else $error("mode fields not stored");
endmodule
`default_nettype wire

// file: test/i2c_host_model.sv
// serial bus host model: driven clock, open-drain data, clock still between frames
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // one 125 ns bit slot; data moves only while the clock is low
  task automatic bit_slot(input logic b, output logic r);
    sda_out = b;
    #31 scl_out = 1'b1;
    #31 r = sda_in;
    #32 scl_out = 1'b0;
    #31;
  endtask
  task automatic start();
    sda_out = 1'b1;
    #31 scl_out = 1'b1;
    #31 sda_out = 1'b0;
    #31 scl_out = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_out = 1'b0;
    #31 scl_out = 1'b1;
    #31 sda_out = 1'b1;
    #63;
  endtask
  task automatic wbyte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ok = ok & (r === 1'b0);
  endtask
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    wbyte({ADDR, 1'b0}, ok);
    wbyte(ptr, ok);
    wbyte(d, ok);
    stop();
  endtask
  // single-byte read, ended with a nack so the slave lets go of data
  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
    logic ok;
    logic r;
    ok = 1'b1;
    start();
    wbyte({ADDR, 1'b0}, ok);
    wbyte(ptr, ok);
    start();
    wbyte({ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(1'b1, r);
    stop();
    if (!ok) d = 8'hxx;
  endtask
endmodule
`default_nettype wire

// file: test/sensor_mode_control_register_tb_top.sv
// bench for the measurement control register block
`include "sensor_ctl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module sensor_mode_control_register_tb_top;
  localparam int MSC = 4;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, scl, sda_h, sda_o, oe_n, hm, run, conv, cst, srdy, boot, ok;
  logic [3:0] exp_code = 4'h0;
  logic [2:0] osc;
  logic [7:0] rd;
  wire sda_w = sda_h & (oe_n | sda_o);
  int n_mismatch = 0, checks_done = 0, cyc = 0, conv_len = 0, gap = 0, last_len = 0, last_gap = 0;
  int n_start = 0, n_ready = 0, boot_len = 0;
  int sp[8] = '{`SPACING_MS_0, `SPACING_MS_1, `SPACING_MS_2, `SPACING_MS_3,
                `SPACING_MS_4, `SPACING_MS_5, `SPACING_MS_6, `SPACING_MS_7};
  always #4 clk = ~clk;
  measurement_control #(.MS_CYCLES(MSC)) dut_u (.clk_sys_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(oe_n), .interval_exp_in(exp_code),
    .height_mode_out(hm), .oversample_code_out(osc), .run_active_out(run), .converting_out(conv),
    .convert_start_out(cst), .sample_ready_out(srdy), .block_reset_out(boot));
  i2c_host_model host_u (.scl_out(scl), .sda_out(sda_h), .sda_in(sda_w));
  always @(posedge clk) begin
    conv_len <= conv ? conv_len + 1 : 0;
    gap <= cst ? 1 : gap + 1;
    if (cst === 1'b1) begin
      last_gap <= gap;
      n_start <= n_start + 1;
    end
    if (srdy === 1'b1) begin
      last_len <= conv_len;
      n_ready <= n_ready + 1;
    end
    if (boot === 1'b1) boot_len <= boot_len + 1;
  end
  // ceiling sized for the longest run with the shortened millisecond
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic miss(input string m);
    n_mismatch++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) miss(m);
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) miss(m);
  endtask
  task automatic chk_num(input int g, input int e, input string m);
    checks_done++;
    if (g != e) miss(m);
  endtask
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e, input string m);
    host_u.reg_read(ptr, rd);
    chk_byte(rd, e, m);
  endtask
  // bounded wait for a new ready (rdy=1) or start (rdy=0) pulse
  task automatic wait_evt(input int old, input int lim, input bit rdy);
    int i;
    for (i = 0; i < lim && (rdy ? n_ready : n_start) == old; i++) @(posedge clk);
    if (i == lim) miss("event missing");
    @(negedge clk);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fields();
    rd_chk(`CTL_ADDR, 8'h00, "reset value");
    host_u.reg_write(8'h27, 8'hff, ok);
    rd_chk(8'h27, 8'h00, "unmapped read");
    host_u.reg_write(`CTL_ADDR, 8'he8, ok);
    chk_bit(ok, 1'b1, "write acked");
    rd_chk(`CTL_ADDR, 8'ha8, "mode and ratio readback");
    chk_bit(hm, 1'b1, "altimeter mode");
    chk_byte({5'h00, osc}, 8'h05, "ratio code out");
  endtask
  task automatic t_reboot(input logic [7:0] wr);
    boot_len = 0;
    host_u.reg_write(`CTL_ADDR, wr, ok);
    repeat (200) @(negedge clk);
    chk_num(boot_len, `BOOT_CYCLES, "boot length");
    chk_bit(run, 1'b0, "standby after boot");
    rd_chk(`CTL_ADDR, 8'h00, "defaults after boot");
    chk_bit(hm, 1'b0, "mode default");
  endtask
  task automatic t_one_shot_standby();
    int old;
    for (int os = 0; os < 8; os++) begin
      old = n_ready;
      host_u.reg_write(`CTL_ADDR, {2'b00, os[2:0], 3'b010}, ok);
      wait_evt(old, sp[os] * MSC + 2000, 1'b1);
      chk_num(last_len, sp[os] * MSC, "conversion length");
      chk_bit(run, 1'b0, "back to standby");
      rd_chk(`CTL_ADDR, {2'b00, os[2:0], 3'b000}, "one-shot cleared");
    end
  endtask
  // clock enable low mid conversion must stretch it by exactly the frozen cycles
  task automatic t_freeze();
    int old;
    old = n_ready;
    host_u.reg_write(`CTL_ADDR, 8'h12, ok);
    @(negedge clk);
    ce = 1'b0;
    repeat (50) @(negedge clk);
    chk_bit(conv, 1'b1, "frozen mid conversion");
    ce = 1'b1;
    wait_evt(old, 200, 1'b1);
    chk_num(last_len, sp[2] * MSC + 50, "freeze stretches conversion");
  endtask
  task automatic t_active();
    int old, old_rdy;
    @(negedge clk);
    exp_code = 4'h1;
    host_u.reg_write(`CTL_ADDR, 8'h01, ok);
    chk_bit(run, 1'b1, "active");
    wait_evt(n_start, 17000, 1'b0);
    wait_evt(n_start, 9000, 1'b0);
    chk_num(last_gap, 2 * `MS_PER_SEC * MSC, "step period");
    wait_evt(n_ready, 200, 1'b1);
    chk_num(last_len, sp[0] * MSC, "periodic conversion length");
    for (int k = 0; k < 2; k++) begin
      old = n_start;
      old_rdy = n_ready;
      host_u.reg_write(`CTL_ADDR, 8'h03, ok);
      wait_evt(old, 1000, 1'b0);
      wait_evt(old_rdy, 200, 1'b1);
      chk_num(last_len, sp[0] * MSC, "one-shot conversion length");
      rd_chk(`CTL_ADDR, 8'h03, "one-shot stays set");
      chk_bit(run, 1'b1, "periodic resumes");
      host_u.reg_write(`CTL_ADDR, 8'h01, ok);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_fields();
    t_reboot(8'hac);
    t_one_shot_standby();
    t_freeze();
    t_active();
    t_reboot(8'h05);
    close_out();
  end
endmodule
`default_nettype wire
